// ### verilog/lnc_cfg.svh
// constants of the lin node controller: offsets, field positions, reset values, counts
`ifndef LNC_CFG_SVH
`define LNC_CFG_SVH

// ********************************************************************
// direct wishbone registers (byte addresses)
// ********************************************************************
`define LNC_OFF_MODE 5'h00
`define LNC_OFF_INDEX 5'h04
`define LNC_OFF_DATA 5'h08
`define LNC_OFF_IST 5'h0C
`define LNC_OFF_IMASK 5'h10

// ********************************************************************
// node_mode_select_reg bits
// ********************************************************************
`define LNC_MODE_EN 7
`define LNC_MODE_MASTER 6
`define LNC_MODE_AUTO_RATE_ENABLE 5

// ********************************************************************
// indirect register indexes
// ********************************************************************
`define LNC_IX_DATA_SEL 3
`define LNC_IX_CTRL 4'h8
`define LNC_IX_STAT 4'h9
`define LNC_IX_SIZE 4'hB
`define LNC_IX_DIV 4'hC
`define LNC_IX_MUL 4'hD
`define LNC_IX_ID 4'hE

// ********************************************************************
// field positions
// ********************************************************************
`define LNC_CTRL_START 0
`define LNC_CTRL_RSTERR 2
`define LNC_CTRL_RSTINT 3
`define LNC_CTRL_TXRX 5
`define LNC_SIZE_ENH 7
`define LNC_LEN_FROM_ID 4'hF
`define LNC_MAX_LEN 4'h8
`define LNC_IRQ_DONE 0
`define LNC_IRQ_ERR 1

// ********************************************************************
// reset values and bit counts
// ********************************************************************
`define LNC_RST_DIV 9'h138
`define LNC_RST_PRE 2'h1
`define LNC_BREAK_BITS 4'hD
`define LNC_BREAK_DETECT 4'hB
`define LNC_STOP_BIT 4'h9
`define LNC_AB_EDGES 4'h4
`define LNC_SYNC_BYTE 8'h55

`endif

// ### verilog/lnc_pkg.sv
// types shared by the lin node controller
package lnc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_BRK, ST_DEL, ST_WBRK, ST_ABD, ST_ABW, ST_LOAD, ST_LOAD2, ST_BYTE
    } lnc_state_e;

    typedef enum logic [1:0] {PH_SYNC, PH_PID, PH_DATA, PH_CHK} lnc_phase_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [2:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } lnc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } lnc_wb_rsp_s;

    typedef struct packed {
        logic en;
        logic master;
        logic auto_rate_enable;
        logic [3:0] idx;
        logic txrx;
        logic start;
        logic [3:0] size;
        logic enh;
        logic [8:0] div;
        logic [4:0] mul;
        logic [1:0] pre;
        logic [5:0] id;
        logic done;
        logic [4:0] errs;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        logic ack;
        logic pend;
        logic [7:0] dat;
        logic tx;
        logic rxp;
        lnc_state_e st;
        lnc_phase_e ph;
        logic go;
        logic [3:0] bytei;
        logic [3:0] lenq;
        logic [3:0] bitc;
        logic [17:0] cnt;
        logic [20:0] meas;
        logic [17:0] per;
        logic [7:0] txb;
        logic [7:0] rb;
    } lnc_regs_s;

endpackage : lnc_pkg

// ### verilog/lnc_msg_ram.sv
// message payload store, eight bytes, registered read
`timescale 1ns/10ps
module lnc_msg_ram (
    input logic clk_sys,
    input logic arst_n,
    input logic we,
    input logic [2:0] addr,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);
    import lnc_pkg::*;

    logic [7:0] mem [8];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[addr];
        end
    end

endmodule : lnc_msg_ram

// ### verilog/lnc_chk.sv
// frame checksum accumulator: carry-wrapping byte sum, inverted on output
`timescale 1ns/10ps
module lnc_chk (
    input logic clk_sys,
    input logic arst_n,
    input logic clr,
    input logic add,
    input logic [7:0] byte_in,
    output logic [7:0] sum_inv
);
    import lnc_pkg::*;

    logic [7:0] sum_q;
    logic [7:0] sum_d;
    logic [8:0] raw;

    always_comb begin
        raw = {1'b0, sum_q} + {1'b0, byte_in};
        sum_d = sum_q;
        if (clr) begin
            sum_d = 8'h00;
        end else if (add) begin
            // the carry folds back into bit 0
            sum_d = raw[7:0] + {7'h00, raw[8]};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sum_q <= 8'h00;
        end else begin
            sum_q <= sum_d;
        end
    end

    assign sum_inv = ~sum_q;

endmodule : lnc_chk

// ### verilog/lnc_top.sv
// lin node controller: wishbone registers, indirect access, frame engine
//
// Operation
// R1 - only mode, interrupt status and interrupt mask are direct; all else goes through index/data pair
// R2 - the index register picks the internal register behind the data window
// R3 - mode bit 6 selects master or slave node, both built in hardware
// R4 - mode bit 5 selects programmed bit timing or bit rate measured on bus
// R5 - software keeps master nodes on manual rate; autobaud only for slaves
// R6 - checksum built and checked in hardware, classic or enhanced
// R7 - software keeps the system clock at 8 MHz or more while in use
// R8 - data registers hold bytes to send and bytes received
// R9 - state machine serialises, deserialises and times every bus bit
// R10 - frame layout and node behaviour follow lin revision 2.1
// R11 - completion and errors seen by interrupt and by polling status
// R12 - bit time is two to (prescaler+1), times divider, times (multiplier+1)
// R13 - master sends break, then sync, then identifier
// R14 - length field is byte count; 1111b takes length from identifier
// R15 - start bit launches frame; interrupt on success or on error
`timescale 1ns/10ps
`include "lnc_cfg.svh"
module lnc_top (
    input logic clk_sys,
    input logic arst_n,
    input lnc_pkg::lnc_wb_req_s wb_req,
    output lnc_pkg::lnc_wb_rsp_s wb_rsp,
    input logic lin_rx,
    output logic lin_tx,
    output logic irq
);
    import lnc_pkg::*;

    localparam lnc_regs_s RST = '{tx: 1'b1, rxp: 1'b1, div: `LNC_RST_DIV,
        pre: `LNC_RST_PRE, st: ST_IDLE, ph: PH_SYNC, default: '0};

    lnc_regs_s r_q;
    lnc_regs_s r_d;

    logic auto_eff;
    logic [12:0] dp;
    logic [17:0] nman;
    logic [17:0] nref;
    logic [17:0] nbit;
    logic [17:0] nhalf;
    logic rx_fall;
    logic drv;
    logic outbit;
    logic [3:0] len_id;
    logic [3:0] len_sel;
    logic ram_we;
    logic [2:0] ram_addr;
    logic [7:0] ram_wd;
    logic [7:0] ram_rd;
    logic eng_ram;
    logic chk_clr;
    logic chk_add;
    logic [7:0] chk_sum;
    logic [4:0] ev_err;
    logic fin;
    logic bus_own;
    logic [7:0] ix_rd;
    logic [31:0] rd_word;

    // protected identifier: two parity bits over the six id bits
    function automatic logic [7:0] lnc_pid(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction : lnc_pid

    // ****************************************************************
    // payload store and checksum
    // ****************************************************************
    lnc_msg_ram u_ram (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wd),
        .rdata(ram_rd)
    );

    lnc_chk u_chk (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clr(chk_clr),
        .add(chk_add),
        .byte_in(r_q.rb),
        .sum_inv(chk_sum)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        auto_eff = r_q.auto_rate_enable & ~r_q.master; // [R4] [R5]
        dp = 13'(r_q.div) << ({1'b0, r_q.pre} + 3'h1);
        nman = 18'(dp) * 18'({1'b0, r_q.mul} + 6'h01); // [R12]
        // autobaud break detection runs on the nominal rate, multiplier unused
        nref = auto_eff ? 18'(dp) : nman;
        nbit = auto_eff ? r_q.per : nman; // [R4]
        nhalf = nbit >> 1;
        rx_fall = r_q.rxp & ~lin_rx;
        drv = (r_q.ph == PH_SYNC || r_q.ph == PH_PID) ? r_q.master : r_q.txrx; // [R3]
        if (r_q.bitc == 4'h0) begin
            outbit = 1'b0;
        end else if (r_q.bitc >= `LNC_STOP_BIT) begin
            outbit = 1'b1;
        end else begin
            outbit = r_q.txb[3'(r_q.bitc - 4'h1)];
        end
        unique case (r_q.rb[5:4]) // [R14]
            2'b10: len_id = 4'h4;
            2'b11: len_id = `LNC_MAX_LEN;
            default: len_id = 4'h2;
        endcase
        if (r_q.size == `LNC_LEN_FROM_ID) begin
            len_sel = len_id; // [R14]
        end else if (r_q.size == 4'h0) begin
            len_sel = 4'h1;
        end else if (r_q.size > `LNC_MAX_LEN) begin
            len_sel = `LNC_MAX_LEN;
        end else begin
            len_sel = r_q.size; // [R14]
        end
        ram_we = 1'b0;
        ram_addr = r_q.idx[2:0];
        ram_wd = wb_req.dat[7:0];
        eng_ram = 1'b0;
        chk_clr = 1'b0;
        chk_add = 1'b0;
        ev_err = 5'h00;
        fin = 1'b0;
        ix_rd = 8'h00;
        rd_word = 32'h0000_0000;
        r_d.rxp = lin_rx;
        r_d.tx = 1'b1;

        // ************************************************************
        // frame engine
        // ************************************************************
        unique case (r_q.st)
            ST_IDLE: begin
                r_d.cnt = 18'h0;
                r_d.bitc = 4'h0;
                r_d.go = 1'b0;
                if (r_q.en && r_q.start) begin // [R15]
                    chk_clr = 1'b1;
                    r_d.ph = PH_SYNC;
                    r_d.st = r_q.master ? ST_BRK : ST_WBRK; // [R3]
                end
            end
            ST_BRK: begin
                r_d.tx = 1'b0; // [R13]
                r_d.cnt = r_q.cnt + 18'h1;
                if (r_q.cnt >= nbit - 18'h1) begin
                    r_d.cnt = 18'h0;
                    r_d.bitc = r_q.bitc + 4'h1;
                    if (r_q.bitc == `LNC_BREAK_BITS - 4'h1) begin
                        r_d.bitc = 4'h0;
                        r_d.st = ST_DEL;
                    end
                end
            end
            ST_DEL: begin
                r_d.cnt = r_q.cnt + 18'h1;
                if (r_q.cnt >= nbit - 18'h1) begin
                    r_d.cnt = 18'h0;
                    r_d.txb = `LNC_SYNC_BYTE; // [R13]
                    r_d.st = ST_BYTE;
                end
            end
            ST_WBRK: begin
                if (!lin_rx) begin
                    r_d.cnt = r_q.cnt + 18'h1;
                    if (r_q.cnt >= nref - 18'h1) begin
                        r_d.cnt = 18'h0;
                        if (r_q.bitc != 4'hF) begin
                            r_d.bitc = r_q.bitc + 4'h1;
                        end
                    end
                end else begin
                    r_d.cnt = 18'h0;
                    r_d.bitc = 4'h0;
                    // a long enough dominant stretch is a break [R10]
                    if (r_q.bitc >= `LNC_BREAK_DETECT) begin
                        r_d.meas = 21'h0;
                        r_d.st = auto_eff ? ST_ABD : ST_BYTE;
                    end
                end
            end
            ST_ABD: begin
                // five falling edges of the sync byte span eight bit times [R4]
                r_d.meas = r_q.meas + 21'h1;
                if (rx_fall) begin
                    r_d.bitc = r_q.bitc + 4'h1;
                    if (r_q.bitc == 4'h0) begin
                        r_d.meas = 21'h0;
                    end
                    if (r_q.bitc == `LNC_AB_EDGES) begin
                        r_d.per = r_q.meas[20:3];
                        r_d.st = ST_ABW;
                    end
                end
            end
            ST_ABW: begin
                r_d.bitc = 4'h0;
                if (lin_rx) begin
                    r_d.ph = PH_PID;
                    r_d.st = ST_BYTE;
                end
            end
            ST_LOAD: begin
                eng_ram = 1'b1;
                ram_addr = r_q.bytei[2:0]; // [R8]
                r_d.st = ST_LOAD2;
            end
            ST_LOAD2: begin
                r_d.txb = (r_q.ph == PH_CHK) ? chk_sum : ram_rd; // [R6] [R8]
                r_d.st = ST_BYTE;
            end
            ST_BYTE: begin
                if (!r_q.go) begin
                    r_d.cnt = 18'h0;
                    r_d.bitc = 4'h0;
                    if (drv || !lin_rx) begin
                        r_d.go = 1'b1;
                    end
                end else begin
                    r_d.tx = drv ? outbit : 1'b1; // [R9]
                    r_d.cnt = r_q.cnt + 18'h1;
                    if (r_q.cnt == nhalf) begin
                        if (r_q.bitc >= 4'h1 && r_q.bitc <= 4'h8) begin
                            r_d.rb = {lin_rx, r_q.rb[7:1]}; // [R9]
                        end
                        if ((r_q.bitc == 4'h0 && lin_rx) ||
                            (r_q.bitc == `LNC_STOP_BIT && !lin_rx)) begin
                            ev_err[4] = 1'b1;
                        end
                        // readback of own transmission catches bus conflicts
                        if (drv && lin_rx != outbit) begin
                            ev_err[0] = 1'b1;
                        end
                    end
                    if (r_q.cnt >= nbit - 18'h1) begin
                        r_d.cnt = 18'h0;
                        r_d.bitc = r_q.bitc + 4'h1;
                        if (r_q.bitc == `LNC_STOP_BIT) begin
                            r_d.go = 1'b0;
                            r_d.bitc = 4'h0;
                            unique case (r_q.ph) // [R10]
                                PH_SYNC: begin
                                    if (r_q.rb != `LNC_SYNC_BYTE) begin
                                        ev_err[3] = 1'b1;
                                    end
                                    r_d.txb = lnc_pid(r_q.id); // [R13]
                                    r_d.ph = PH_PID;
                                end
                                PH_PID: begin
                                    chk_add = r_q.enh; // [R6]
                                    if (!r_q.master) begin
                                        r_d.id = r_q.rb[5:0];
                                    end
                                    if (r_q.rb != lnc_pid(r_q.rb[5:0])) begin
                                        ev_err[2] = 1'b1;
                                    end
                                    r_d.lenq = len_sel; // [R14]
                                    r_d.bytei = 4'h0;
                                    r_d.ph = PH_DATA;
                                    r_d.st = r_q.txrx ? ST_LOAD : ST_BYTE;
                                end
                                PH_DATA: begin
                                    chk_add = 1'b1; // [R6]
                                    if (!drv) begin
                                        eng_ram = 1'b1;
                                        ram_we = 1'b1; // [R8]
                                        ram_addr = r_q.bytei[2:0];
                                        ram_wd = r_q.rb;
                                    end
                                    r_d.bytei = r_q.bytei + 4'h1;
                                    if (r_q.bytei + 4'h1 >= r_q.lenq) begin
                                        r_d.ph = PH_CHK;
                                    end
                                    r_d.st = r_q.txrx ? ST_LOAD : ST_BYTE;
                                end
                                PH_CHK: begin
                                    if (!drv && r_q.rb != chk_sum) begin
                                        ev_err[1] = 1'b1; // [R6]
                                    end
                                    fin = 1'b1;
                                end
                            endcase
                            // any fault aborts the frame at the byte boundary
                            if ((r_q.errs | ev_err) != 5'h00) begin
                                fin = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase
        if (fin) begin
            r_d.st = ST_IDLE;
            r_d.start = 1'b0;
        end
        if (!r_q.en) begin
            r_d.st = ST_IDLE;
            r_d.go = 1'b0;
        end

        // ************************************************************
        // wishbone slave
        // ************************************************************
        bus_own = ~eng_ram;
        if (r_q.idx[`LNC_IX_DATA_SEL] == 1'b0) begin
            ix_rd = ram_rd; // [R2] [R8]
        end else begin
            unique case (r_q.idx) // [R2]
                `LNC_IX_CTRL: ix_rd = {2'h0, r_q.txrx, 4'h0, r_q.start};
                `LNC_IX_STAT: ix_rd = {r_q.errs, |r_q.errs, r_q.st != ST_IDLE, r_q.done}; // [R11]
                `LNC_IX_SIZE: ix_rd = {r_q.enh, 3'h0, r_q.size};
                `LNC_IX_DIV: ix_rd = r_q.div[7:0];
                `LNC_IX_MUL: ix_rd = {r_q.pre, r_q.mul, r_q.div[8]};
                `LNC_IX_ID: ix_rd = {2'h0, r_q.id};
                default: ix_rd = 8'h00;
            endcase
        end
        unique case ({wb_req.adr, 2'b00}) // [R1]
            `LNC_OFF_MODE: rd_word = {24'h0, r_q.en, r_q.master, r_q.auto_rate_enable, 5'h00};
            `LNC_OFF_INDEX: rd_word = {28'h0, r_q.idx};
            `LNC_OFF_DATA: rd_word = {24'h0, ix_rd};
            `LNC_OFF_IST: rd_word = {30'h0, r_q.ist};
            `LNC_OFF_IMASK: rd_word = {30'h0, r_q.imask};
            default: rd_word = 32'h0000_0000;
        endcase
        r_d.ack = 1'b0;
        if (!(wb_req.cyc && wb_req.stb) || r_q.ack) begin
            r_d.pend = 1'b0;
        end else if (!r_q.pend) begin
            // first cycle only presents the index to the store
            r_d.pend = bus_own;
        end else if (!bus_own) begin
            r_d.pend = 1'b0;
        end else begin
            r_d.pend = 1'b0;
            r_d.ack = 1'b1;
            r_d.dat = rd_word[7:0];
            if (wb_req.we && wb_req.sel[0]) begin
                unique case ({wb_req.adr, 2'b00}) // [R1]
                    `LNC_OFF_MODE: begin
                        r_d.en = wb_req.dat[`LNC_MODE_EN];
                        r_d.master = wb_req.dat[`LNC_MODE_MASTER]; // [R3]
                        r_d.auto_rate_enable = wb_req.dat[`LNC_MODE_AUTO_RATE_ENABLE]; // [R4]
                    end
                    `LNC_OFF_INDEX: r_d.idx = wb_req.dat[3:0];
                    `LNC_OFF_DATA: begin
                        if (r_q.idx[`LNC_IX_DATA_SEL] == 1'b0) begin
                            ram_we = 1'b1; // [R2] [R8]
                        end
                        unique case (r_q.idx) // [R2]
                            `LNC_IX_CTRL: begin
                                r_d.txrx = wb_req.dat[`LNC_CTRL_TXRX];
                                if (wb_req.dat[`LNC_CTRL_START]) begin
                                    r_d.start = 1'b1; // [R15]
                                    r_d.done = 1'b0;
                                    r_d.errs = 5'h00;
                                end
                                if (wb_req.dat[`LNC_CTRL_RSTERR]) begin
                                    r_d.errs = 5'h00;
                                end
                                if (wb_req.dat[`LNC_CTRL_RSTINT]) begin
                                    r_d.ist = 2'h0;
                                end
                            end
                            `LNC_IX_SIZE: begin
                                r_d.enh = wb_req.dat[`LNC_SIZE_ENH]; // [R6]
                                r_d.size = wb_req.dat[3:0];
                            end
                            `LNC_IX_DIV: r_d.div[7:0] = wb_req.dat[7:0];
                            `LNC_IX_MUL: begin
                                r_d.pre = wb_req.dat[7:6];
                                r_d.mul = wb_req.dat[5:1];
                                r_d.div[8] = wb_req.dat[0];
                            end
                            `LNC_IX_ID: r_d.id = wb_req.dat[5:0];
                            default: begin
                            end
                        endcase
                    end
                    `LNC_OFF_IST: r_d.ist = r_q.ist & ~wb_req.dat[1:0];
                    `LNC_OFF_IMASK: r_d.imask = wb_req.dat[1:0];
                    default: begin
                    end
                endcase
            end
        end

        // hardware events land last so a same-cycle software clear loses
        r_d.errs = r_d.errs | ev_err; // [R11]
        if (fin) begin
            r_d.done = 1'b1; // [R11]
            r_d.ist[`LNC_IRQ_DONE] = 1'b1; // [R15]
            if ((r_q.errs | ev_err) != 5'h00) begin
                r_d.ist[`LNC_IRQ_ERR] = 1'b1; // [R15]
            end
        end
        r_d.irq = |(r_d.ist & r_d.imask); // [R11]
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign wb_rsp = '{ack: r_q.ack, dat: {24'h0, r_q.dat}};
    assign lin_tx = r_q.tx;
    assign irq = r_q.irq;

endmodule : lnc_top

// ### dv/lnc_top_assertions.sv
// port assertions for the lin node controller
`timescale 1ns/10ps
module lnc_checker (
    input logic clk_sys,
    input logic arst_n,
    input lnc_pkg::lnc_wb_req_s wb_req,
    input lnc_pkg::lnc_wb_rsp_s wb_rsp,
    input logic lin_rx,
    input logic lin_tx,
    input logic irq
);
    import lnc_pkg::*;
    logic req;
    logic ack;
    logic wr;
    assign req = wb_req.cyc & wb_req.stb;
    assign ack = wb_rsp.ack;
    assign wr = ack & wb_req.we & wb_req.sel[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_ACK_ONE: assert property (ack |=> !ack)
        else $error("ack held too long");
    AST_ACK_REQ: assert property (ack |-> req && $past(req))
        else $error("ack without request");
    AST_ACK_TIME: assert property ($rose(req) |-> ##[2:4] ack)
        else $error("ack late");
    AST_DAT_HI: assert property (ack |-> wb_rsp.dat[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_UNMAP: assert property (ack && !wb_req.we && wb_req.adr > 3'h4
        |-> wb_rsp.dat == 32'h0)
        else $error("unmapped read not zero");
    AST_MASK_OFF: assert property (wr && wb_req.adr == 3'h4 && wb_req.dat[1:0] == 2'h0
        |-> ##2 !irq)
        else $error("irq with mask clear");
    AST_OFF_IDLE: assert property (wr && wb_req.adr == 3'h0 && !wb_req.dat[7]
        |-> ##[1:3] lin_tx)
        else $error("bus driven while disabled");
    // irq and ack are registered on the same edge, so the fall lines up with the ack cycle
    AST_IRQ_FALL: assert property ($fell(irq) |-> wr)
        else $error("irq dropped without write");
    cover property ($rose(irq));
    cover property (ack && wb_req.adr > 3'h4);
    cover property ($fell(lin_tx));
endmodule : lnc_checker

bind lnc_top lnc_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .lin_rx(lin_rx), .lin_tx(lin_tx), .irq(irq));

// ### dv/lnc_bus_node.sv
// far lin node: wired-and bus, byte monitor, dominant jam on command
`timescale 1ns/10ps
module lnc_bus_node #(
    parameter int T = 400
) (
    input logic clk_sys,
    input logic lin_tx,
    input logic jam,
    output logic lin_rx
);
    logic [7:0] got [0:15];
    int n = 0;
    // dominant wins, so a jam also corrupts the controller's own readback
    assign lin_rx = lin_tx & ~jam;
    always begin
        @(negedge lin_rx);
        repeat (T / 2) @(posedge clk_sys);
        for (int b = 0; b < 8; b++) begin
            repeat (T) @(posedge clk_sys);
            got[n][b] = lin_rx;
        end
        n++;
    end
endmodule : lnc_bus_node

// ### dv/tb.sv
// testbench for the lin node controller
`timescale 1ns/10ps
module tb;
    import lnc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic jam = 1'b0;
    logic lin_rx, lin_tx, irq;
    lnc_wb_req_s wb_req = '0;
    lnc_wb_rsp_s wb_rsp;
    logic [7:0] rd;
    logic [7:0] exp_b [0:4] = '{8'h00, 8'h55, 8'h11, 8'hA5, 8'h49};
    int err_total = 0;
    int checks_done = 0;
    int cyc_n = 0;
    always #20 clk_sys = ~clk_sys;
    lnc_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .lin_rx(lin_rx), .lin_tx(lin_tx), .irq(irq));
    lnc_bus_node #(.T(400)) node (.clk_sys(clk_sys), .lin_tx(lin_tx), .jam(jam),
        .lin_rx(lin_rx));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
        wb_req <= '{1'b1, 1'b1, we, a[4:2], 4'hF, {24'h0, d}};
        do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat[7:0];
        wb_req <= '0;
        @(posedge clk_sys);
    endtask : wb
    task automatic iw(input logic [3:0] i, input logic [7:0] d);
        wb(1'b1, 5'h04, {4'h0, i});
        wb(1'b1, 5'h08, d);
    endtask : iw
    task automatic ir(input logic [3:0] i);
        wb(1'b1, 5'h04, {4'h0, i});
        wb(1'b0, 5'h08, 8'h00);
    endtask : ir
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        wb(1'b0, 5'h00, 8'h00);
        chk(rd, 8'h00);
        ir(4'hC);
        chk(rd, 8'h38);
        ir(4'hD);
        chk(rd, 8'h41);
        wb(1'b0, 5'h14, 8'h00);
        chk(rd, 8'h00);
        $display("reset values test ended");
        // master with manual rate: 200 * 2 * 1 = 400 clocks a bit
        wb(1'b1, 5'h00, 8'hC0);
        iw(4'hC, 8'hC8);
        iw(4'hD, 8'h00);
        iw(4'hB, 8'h81);
        iw(4'hE, 8'h11);
        iw(4'h0, 8'hA5);
        ir(4'h0);
        chk(rd, 8'hA5);
        wb(1'b1, 5'h10, 8'h01);
        iw(4'h8, 8'h21);
        while (irq !== 1'b1) @(posedge clk_sys);
        for (int k = 0; k < 5; k++) chk(node.got[k], exp_b[k]);
        ir(4'h9);
        chk(rd, 8'h01);
        wb(1'b0, 5'h0C, 8'h00);
        chk(rd, 8'h01);
        wb(1'b1, 5'h0C, 8'h01);
        @(posedge clk_sys);
        chk({7'h0, irq}, 8'h00);
        $display("master send test ended");
        // classic checksum; far node jams the bus once it has captured the identifier byte, before its stop bit
        wb(1'b1, 5'h10, 8'h00);
        iw(4'hB, 8'h01);
        iw(4'h8, 8'h21);
        while (node.n < 8) @(posedge clk_sys);
        jam <= 1'b1;
        rd = 8'h00;
        while (rd[0] !== 1'b1) ir(4'h9);
        jam <= 1'b0;
        chk(rd & 8'h05, 8'h05);
        chk({7'h0, irq}, 8'h00);
        wb(1'b0, 5'h0C, 8'h00);
        chk(rd, 8'h03);
        wb(1'b1, 5'h10, 8'h03);
        @(posedge clk_sys);
        chk({7'h0, irq}, 8'h01);
        iw(4'h8, 8'h08);
        @(posedge clk_sys);
        chk({7'h0, irq}, 8'h00);
        wb(1'b1, 5'h00, 8'h00);
        $display("bus error test ended");
        complete_run();
    end
endmodule : tb
